/* rtl/gbar_pkg.sv */
// Register map, field layout and frame constants of the negotiation bank
package gbar_pkg;
   // Register addresses on the serial management interface
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   localparam logic [4:0] REG_ADV = 5'h04;
   localparam logic [4:0] REG_LPBASE = 5'h05;
   localparam logic [4:0] REG_EXP = 5'h06;
   localparam logic [4:0] REG_NPTX = 5'h07;
   localparam logic [4:0] REG_LPNP = 5'h08;
   localparam logic [4:0] REG_GIG = 5'h09;
   // Advertisement fields
   localparam int ADV_NP_BIT = 15;
   localparam int ADV_SEL_LSB = 0;
   localparam int ADV_SEL_MSB = 4;
   localparam int ADV_TECH_LSB = 5;
   localparam int ADV_TECH_MSB = 12;
   // Gigabit control fields, held as bits 15:8 of the word
   localparam int GIG_LSB = 8;
   localparam int GIG_TEST_MSB = 7;
   localparam int GIG_TEST_LSB = 5;
   localparam int GIG_MAN_EN = 4;
   localparam int GIG_MAN_VAL = 3;
   localparam int GIG_PORT = 2;
   localparam int GIG_FD = 1;
   localparam int GIG_HD = 0;
   // Reset values
   localparam logic [7:0] GIG_RESET = 8'h00;
   localparam logic [15:0] NPTX_RESET = 16'h0000;
   localparam logic [15:0] LP_RESET = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
   // Frame layout
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [4:0] HDR_LAST = 5'h0C;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [4:0] RD_BITS = 5'h10;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   typedef enum logic [5:0] {
      GBAR_PRE = 6'b000001,
      GBAR_HDR = 6'b000010,
      GBAR_TARD = 6'b000100,
      GBAR_RD = 6'b001000,
      GBAR_TAWR = 6'b010000,
      GBAR_WR = 6'b100000
   } gbar_state_e;
endpackage

/* rtl/gbar_edge.sv */
// Rising edge detector for the sampled management clock
`timescale 1ns/10ps
module gbar_edge (
   input wire logic clock, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic level, // Sampled level
   output logic rise // One-cycle pulse on 0 to 1
);
   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = level;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prev <= 1'b1;
      end else begin
         prev <= next_prev;
      end
   end

   assign rise = level & ~prev;
endmodule

/* rtl/gbar_role.sv */
// Role request from manual forcing or port-type preference
`timescale 1ns/10ps
module gbar_role (
   input wire logic clock, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic manual_en, // Manual role forcing enabled
   input wire logic manual_master, // Forced role, 1 master
   input wire logic port_multi, // Multiport, prefers master
   output logic role_forced, // Role is forced, not preferred
   output logic role_master // Requested role, 1 master
);
   logic next_forced;
   logic next_master;

   always_comb begin
      next_forced = manual_en;
      next_master = manual_en ? manual_master : port_multi;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         role_forced <= 1'b0;
         role_master <= 1'b0;
      end else begin
         role_forced <= next_forced;
         role_master <= next_master;
      end
   end

   chk_role_manual: assert property (@(posedge clock) disable iff (!nrst)
      manual_en |=> role_forced && role_master == $past(manual_master))
      else $error("manual role not applied");
   chk_role_pref: assert property (@(posedge clock) disable iff (!nrst)
      !manual_en |=> !role_forced && role_master == $past(port_multi))
      else $error("port preference not applied");
   chk_role_ignore: assert property (@(posedge clock) disable iff (!nrst)
      !manual_en && $changed(manual_master) && $stable(port_multi)
      |=> $stable(role_master))
      else $error("manual value leaked while disabled");
endmodule

/* rtl/gbar_regs.sv */
// Negotiation management register bank with serial management slave
`timescale 1ns/10ps
module gbar_regs import gbar_pkg::*; #(
   parameter logic [4:0] SEL_RST = 5'h01, // Selector reset code
   parameter logic [7:0] TECH_RST = 8'h00 // Technology ability reset
) (
   input wire logic clock, // System clock, 200 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic [4:0] phy_addr, // Own management address
   input wire logic mdc, // Management clock, sampled
   input wire logic mdio_in, // Management data, pin level
   output logic mdio_out, // Management data, driven value
   output logic mdio_oe_n, // Low while driving data
   input wire logic [15:0] ctrl_in, // Control word from core
   input wire logic [15:0] stat_in, // Status word from core
   input wire logic [15:0] exp_in, // Expansion word from core
   input wire logic lp_base_we, // Partner base page received
   input wire logic [15:0] lp_base_data, // Partner base page word
   input wire logic lp_np_we, // Partner next page received
   input wire logic [15:0] lp_np_data, // Partner next page word
   output logic [15:0] adv_word, // Local advertisement
   output logic [15:0] np_tx_word, // Next page to send
   output logic np_tx_loaded, // Pulse, next page written
   output logic [2:0] test_mode, // Transmit test mode
   output logic adv_1000_fd, // Advertise gigabit full duplex
   output logic adv_1000_hd, // Advertise gigabit half duplex
   output logic role_forced, // Role forced by manager
   output logic role_master // Requested role, 1 master
);
   if (SEL_RST == 5'h00) begin : g_bad_sel
      $error("selector reset code zero is reserved");
   end

   // Frame engine state
   gbar_state_e st;
   gbar_state_e next_st;
   logic [5:0] pre;
   logic [5:0] next_pre;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [15:0] sh;
   logic [15:0] next_sh;
   logic [4:0] reg_a;
   logic [4:0] next_reg_a;
   logic next_out;
   logic next_oe_n;
   logic wr;
   logic next_wr;
   logic [15:0] wdata;
   logic [15:0] next_wdata;
   logic rise;
   logic [15:0] rd_word;
   logic [4:0] hdr_addr;

   // Register contents
   logic [15:0] next_adv;
   logic [15:0] next_np;
   logic next_np_ld;
   logic [7:0] gig;
   logic [7:0] next_gig;
   logic [15:0] lpb;
   logic [15:0] next_lpb;
   logic [15:0] lpn;
   logic [15:0] next_lpn;

   gbar_edge u_edge (
      .clock(clock),
      .nrst(nrst),
      .level(mdc),
      .rise(rise)
   );

   // Read data picked as the last address bit arrives
   assign hdr_addr = {sh[3:0], mdio_in};

   always_comb begin
      unique case (hdr_addr)
         REG_CTRL: rd_word = ctrl_in;
         REG_STAT: rd_word = stat_in;
         REG_ADV: rd_word = adv_word;
         REG_LPBASE: rd_word = lpb;
         REG_EXP: rd_word = exp_in;
         REG_NPTX: rd_word = np_tx_word;
         REG_LPNP: rd_word = lpn;
         REG_GIG: rd_word = {gig, 8'h00};
         default: rd_word = RD_UNMAPPED;
      endcase
   end

   always_comb begin
      next_st = st;
      next_pre = pre;
      next_cnt = cnt;
      next_sh = sh;
      next_reg_a = reg_a;
      next_out = mdio_out;
      next_oe_n = mdio_oe_n;
      next_wr = 1'b0;
      next_wdata = wdata;
      if (rise) begin
         unique case (st)
            GBAR_PRE: begin
               if (mdio_in) begin
                  if (pre != PRE_LEN) begin
                     next_pre = pre + 6'h01;
                  end
               end else begin
                  next_pre = 6'h00;
                  if (pre == PRE_LEN) begin
                     next_st = GBAR_HDR;
                     next_cnt = 5'h00;
                  end
               end
            end
            GBAR_HDR: begin
               next_sh = {sh[14:0], mdio_in};
               next_cnt = cnt + 5'h01;
               if (cnt == HDR_LAST) begin
                  next_cnt = 5'h00;
                  next_reg_a = hdr_addr;
                  next_st = GBAR_PRE;
                  if (sh[11] && sh[8:4] == phy_addr) begin
                     if (sh[10:9] == OP_READ) begin
                        next_st = GBAR_TARD;
                        next_sh = rd_word;
                     end else if (sh[10:9] == OP_WRITE) begin
                        next_st = GBAR_TAWR;
                     end
                  end
               end
            end
            GBAR_TARD: begin
               next_oe_n = 1'b0;
               next_out = 1'b0;
               next_st = GBAR_RD;
            end
            GBAR_RD: begin
               if (cnt == RD_BITS) begin
                  next_oe_n = 1'b1;
                  next_out = 1'b0;
                  next_cnt = 5'h00;
                  next_st = GBAR_PRE;
               end else begin
                  next_out = sh[15];
                  next_sh = {sh[14:0], 1'b0};
                  next_cnt = cnt + 5'h01;
               end
            end
            GBAR_TAWR: begin
               next_cnt = cnt + 5'h01;
               if (cnt == TA_LAST) begin
                  next_cnt = 5'h00;
                  next_st = GBAR_WR;
               end
            end
            GBAR_WR: begin
               next_sh = {sh[14:0], mdio_in};
               next_cnt = cnt + 5'h01;
               if (cnt == DATA_LAST) begin
                  next_cnt = 5'h00;
                  next_wr = 1'b1;
                  next_wdata = {sh[14:0], mdio_in};
                  next_st = GBAR_PRE;
               end
            end
            default: begin
               next_st = GBAR_PRE;
               next_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st <= GBAR_PRE;
         pre <= 6'h00;
         cnt <= 5'h00;
         sh <= 16'h0000;
         reg_a <= 5'h00;
         mdio_out <= 1'b0;
         mdio_oe_n <= 1'b1;
         wr <= 1'b0;
         wdata <= 16'h0000;
      end else begin
         st <= next_st;
         pre <= next_pre;
         cnt <= next_cnt;
         sh <= next_sh;
         reg_a <= next_reg_a;
         mdio_out <= next_out;
         mdio_oe_n <= next_oe_n;
         wr <= next_wr;
         wdata <= next_wdata;
      end
   end

   // Register writes and partner page capture
   always_comb begin
      next_adv = adv_word;
      next_np = np_tx_word;
      next_np_ld = 1'b0;
      next_gig = gig;
      next_lpb = lpb;
      next_lpn = lpn;
      if (wr) begin
         unique case (reg_a)
            REG_ADV: begin
               next_adv = wdata;
               next_adv[ADV_NP_BIT] = 1'b1;
            end
            REG_NPTX: begin
               next_np = wdata;
               next_np_ld = 1'b1;
            end
            REG_GIG: next_gig = wdata[15:GIG_LSB];
            default: next_gig = gig;
         endcase
      end
      if (lp_base_we) begin
         next_lpb = lp_base_data;
      end
      if (lp_np_we) begin
         next_lpn = lp_np_data;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         adv_word <= {1'b1, 2'h0, TECH_RST, SEL_RST};
         np_tx_word <= NPTX_RESET;
         np_tx_loaded <= 1'b0;
         gig <= GIG_RESET;
         lpb <= LP_RESET;
         lpn <= LP_RESET;
      end else begin
         adv_word <= next_adv;
         np_tx_word <= next_np;
         np_tx_loaded <= next_np_ld;
         gig <= next_gig;
         lpb <= next_lpb;
         lpn <= next_lpn;
      end
   end

   assign test_mode = gig[GIG_TEST_MSB:GIG_TEST_LSB];
   assign adv_1000_fd = gig[GIG_FD];
   assign adv_1000_hd = gig[GIG_HD];

   gbar_role u_role (
      .clock(clock),
      .nrst(nrst),
      .manual_en(gig[GIG_MAN_EN]),
      .manual_master(gig[GIG_MAN_VAL]),
      .port_multi(gig[GIG_PORT]),
      .role_forced(role_forced),
      .role_master(role_master)
   );

   chk_sel_write: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_ADV |=> adv_word[4:0] == $past(wdata[4:0]))
      else $error("selector not written");
   chk_tech_write: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_ADV |=> adv_word[12:5] == $past(wdata[12:5]))
      else $error("technology field not written");
   chk_np_request: assert property (@(posedge clock) disable iff (!nrst)
      adv_word[15] == 1'b1)
      else $error("next page request bit cleared");
   chk_lp_separate: assert property (@(posedge clock) disable iff (!nrst)
      lp_np_we && !lp_base_we |=> $stable(lpb) && lpn == $past(lp_np_data))
      else $error("next page landed in base page register");
   chk_test_mode: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_GIG |=> test_mode == $past(wdata[15:13]))
      else $error("test mode not written");
   chk_gig_fd: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_GIG |=> adv_1000_fd == $past(wdata[9]))
      else $error("full duplex advert not written");
   chk_gig_hd: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_GIG |=> adv_1000_hd == $past(wdata[8]))
      else $error("half duplex advert not written");
   chk_nptx_write: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a == REG_NPTX |=> np_tx_word == $past(wdata) && np_tx_loaded)
      else $error("next page transmit not written");
   chk_ro_write: assert property (@(posedge clock) disable iff (!nrst)
      wr && reg_a != REG_ADV && reg_a != REG_NPTX && reg_a != REG_GIG
      |=> $stable(adv_word) && $stable(np_tx_word) && $stable(gig)
      && !np_tx_loaded)
      else $error("read-only write had an effect");
   chk_rd_drive: assert property (@(posedge clock) disable iff (!nrst)
      st == GBAR_TARD && rise |=> !mdio_oe_n && !mdio_out)
      else $error("turnaround zero not driven");
   chk_rd_release: assert property (@(posedge clock) disable iff (!nrst)
      st == GBAR_RD && rise && cnt == RD_BITS |=> mdio_oe_n)
      else $error("data line not released after read");
endmodule

/* sim/gbar_sta.sv */
// Station management model that runs serial frames on mdc and mdio
`timescale 1ns/10ps
module gbar_sta import gbar_pkg::*; (
   input wire logic clock, // System clock
   input wire logic pin, // Resolved data line level
   output logic mdc, // Management clock
   output logic drv_en, // Station drives data line
   output logic drv_bit // Value driven by station
);
   initial begin
      mdc = 1'b0;
      drv_en = 1'b0;
      drv_bit = 1'b0;
   end
   // Clock idles low between frames; line sampled just before each rise
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd, output logic ta0);
      logic [63:0] seq;
      seq = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      ta0 = 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(negedge clock);
         mdc = 1'b0;
         drv_en = (op == OP_WRITE) || (i < 46);
         drv_bit = seq[63 - i];
         repeat (2) @(negedge clock);
         if (i == 47) ta0 = pin;
         if (i >= 48) rd = {rd[14:0], pin};
         mdc = 1'b1;
         @(negedge clock);
      end
      @(negedge clock);
      mdc = 1'b0;
      drv_en = 1'b0;
      repeat (4) @(negedge clock);
   endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the negotiation management register bank
`timescale 1ns/10ps
module testbench;
   import gbar_pkg::*;
   localparam logic [4:0] PA = 5'h05;
   logic clock, nrst, mdc, drv_en, drv_bit, pin, mdio_out, mdio_oe_n;
   logic [15:0] ctrl_in, stat_in, exp_in, lp_base_data, lp_np_data;
   logic lp_base_we, lp_np_we, np_tx_loaded, adv_1000_fd, adv_1000_hd;
   logic role_forced, role_master, ta0;
   logic [15:0] adv_word, np_tx_word, rd;
   logic [2:0] test_mode;
   int err_total, n_compared, n_loaded;
   // Pull-up holds the line high when nobody drives
   assign pin = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);
   gbar_regs dut (.clock(clock), .nrst(nrst), .phy_addr(PA), .mdc(mdc),
      .mdio_in(pin), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
      .ctrl_in(ctrl_in), .stat_in(stat_in), .exp_in(exp_in),
      .lp_base_we(lp_base_we), .lp_base_data(lp_base_data),
      .lp_np_we(lp_np_we), .lp_np_data(lp_np_data),
      .adv_word(adv_word), .np_tx_word(np_tx_word),
      .np_tx_loaded(np_tx_loaded), .test_mode(test_mode),
      .adv_1000_fd(adv_1000_fd), .adv_1000_hd(adv_1000_hd),
      .role_forced(role_forced), .role_master(role_master));
   gbar_sta sta (.clock(clock), .pin(pin), .mdc(mdc), .drv_en(drv_en),
      .drv_bit(drv_bit));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (np_tx_loaded === 1'b1) n_loaded++;
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp,
         input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      sta.frame(OP_WRITE, PA, ra, wd, rd, ta0);
   endtask
   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
      sta.frame(OP_READ, PA, ra, 16'h0000, rd, ta0);
      cmp_w({15'h0000, ta0}, 16'h0000, "turnaround");
      cmp_w(rd, exp, "read data");
   endtask
   task automatic t_reset;
      cmp_w(adv_word, 16'h8001, "adv port");
      cmp_w({13'h0000, test_mode}, 16'h0000, "test mode");
      cmp_w({14'h0000, role_forced, role_master}, 16'h0000, "role");
      rd_chk(REG_ADV, 16'h8001);
      rd_chk(REG_NPTX, NPTX_RESET);
      rd_chk(REG_LPBASE, LP_RESET);
      rd_chk(REG_LPNP, LP_RESET);
      rd_chk(REG_GIG, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_adv_np;
      int n0;
      wr(REG_ADV, 16'h1FE1);
      cmp_w(adv_word, 16'h9FE1, "adv port");
      rd_chk(REG_ADV, 16'h9FE1);
      n0 = n_loaded;
      wr(REG_NPTX, 16'h5A5A);
      cmp_w(np_tx_word, 16'h5A5A, "np port");
      cmp_w(16'(n_loaded - n0), 16'h0001, "np pulse");
      rd_chk(REG_NPTX, 16'h5A5A);
      $display("test advertise and next page done");
   endtask
   task automatic t_readonly;
      logic [4:0] ra [6];
      logic [15:0] ex [6];
      ra = '{REG_CTRL, REG_STAT, REG_LPBASE, REG_EXP, REG_LPNP, 5'h1F};
      ex = '{ctrl_in, stat_in, 16'h1234, exp_in, 16'hABCD, RD_UNMAPPED};
      @(negedge clock);
      lp_base_data = 16'h1234;
      lp_base_we = 1'b1;
      @(negedge clock);
      lp_base_we = 1'b0;
      lp_np_data = 16'hABCD;
      lp_np_we = 1'b1;
      @(negedge clock);
      lp_np_we = 1'b0;
      for (int i = 0; i < 6; i++) wr(ra[i], 16'hFFFF);
      for (int i = 0; i < 6; i++) rd_chk(ra[i], ex[i]);
      cmp_w(np_tx_word, 16'h5A5A, "np after stray writes");
      cmp_w(adv_word, 16'h9FE1, "adv after stray writes");
      $display("test read-only done");
   endtask
   task automatic t_gig;
      logic [15:0] gw [8];
      logic [15:0] w;
      // Last step flips the manual value while forcing is off
      gw = '{16'hE000, 16'h1800, 16'h1000, 16'h1400, 16'h0400, 16'h0200,
         16'h0100, 16'h0800};
      for (int i = 0; i < 8; i++) begin
         w = gw[i];
         wr(REG_GIG, w);
         cmp_w({13'h0000, test_mode}, {13'h0000, w[15:13]}, "tm");
         cmp_w({14'h0000, adv_1000_fd, adv_1000_hd},
            {14'h0000, w[9:8]}, "duplex");
         cmp_w({15'h0000, role_forced}, {15'h0000, w[12]}, "forced");
         cmp_w({15'h0000, role_master},
            {15'h0000, w[12] ? w[11] : w[10]}, "master");
         rd_chk(REG_GIG, w);
      end
      $display("test gigabit control done");
   endtask
   task automatic t_refuse;
      sta.frame(OP_WRITE, PA ^ 5'h01, REG_GIG, 16'hE000, rd, ta0);
      sta.frame(2'h3, PA, REG_GIG, 16'hE000, rd, ta0);
      sta.frame(OP_READ, PA ^ 5'h01, REG_GIG, 16'h0000, rd, ta0);
      cmp_w(rd, 16'hFFFF, "foreign read");
      cmp_w({15'h0000, ta0}, 16'h0001, "foreign turnaround");
      rd_chk(REG_GIG, 16'h0800);
      $display("test refused frames done");
   endtask
   task automatic t_midreset;
      @(negedge clock);
      nrst = 1'b0;
      repeat (3) @(negedge clock);
      cmp_w(adv_word, 16'h8001, "adv in reset");
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      cmp_w(np_tx_word, NPTX_RESET, "np after reset");
      cmp_w({13'h0000, test_mode}, 16'h0000, "tm after reset");
      cmp_w({14'h0000, adv_1000_fd, adv_1000_hd}, 16'h0000,
         "duplex after reset");
      cmp_w({14'h0000, role_forced, role_master}, 16'h0000,
         "role after reset");
      rd_chk(REG_GIG, 16'h0000);
      rd_chk(REG_LPBASE, LP_RESET);
      $display("test mid-run reset done");
   endtask
   initial begin
      #200000;
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      nrst = 1'b0;
      ctrl_in = 16'h1140;
      stat_in = 16'h796D;
      exp_in = 16'h000F;
      lp_base_we = 1'b0;
      lp_np_we = 1'b0;
      lp_base_data = 16'h0000;
      lp_np_data = 16'h0000;
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      t_reset();
      t_adv_np();
      t_readonly();
      t_gig();
      t_refuse();
      t_midreset();
      conclude();
   end
endmodule
